// ==== logic/qps_defs.vh ====
// constants for the qos priority queue scheduler
// assumes byte-wide ethernet frames starting at the destination mac address
//
// Contract
// - four separate egress queues; higher priorities travel a different queue
// - every frame gets a priority 0..7 that selects its service
// - 802.1q tag sits right after destination and source mac addresses
// - untagged frames take a default priority, normally 0
// - remarking overwrites priority; the original value is not kept
// - each priority maps to a fixed queue; frame goes to that queue
// - at queue head, tagged egress rewrites the tag with the new priority
// - classification and remarking finish before the frame is queued
// - weighted-fair mode serves all queues, favours high, never starves low
// - strict mode always sends from the highest non-empty queue
// - 6-bit dscp selects one of 64 code points, each mapped to a level
// - weighted-fair weights are 8, 4, 2, 1 from highest queue to lowest
// - default map: 0,1 lowest; 2,3 second; 4,5 third; 6,7 highest
// - priority from tos first, then 802.1p tag, else port default
`ifndef QPS_DEFS_VH
`define QPS_DEFS_VH

`define QPS_IDX_W        11
`define QPS_IDX_TYPE_HI  11'h00c
`define QPS_IDX_TYPE_LO  11'h00d
`define QPS_IDX_TCI      11'h00e
`define QPS_IDX_TOS_UT   11'h00f
`define QPS_IDX_TYPE2_HI 11'h010
`define QPS_IDX_TYPE2_LO 11'h011
`define QPS_IDX_TOS_T    11'h013

`define QPS_TPID         16'h8100
`define QPS_ETYPE_IP4    16'h0800

`define QPS_DEF_PRI      3'h0
`define QPS_DEF_COS_MAP  16'hfa50

`define QPS_CRED_W       4
`define QPS_WGT_Q3       4'h8
`define QPS_WGT_Q2       4'h4
`define QPS_WGT_Q1       4'h2
`define QPS_WGT_Q0       4'h1

`define QPS_MODE_WFQ     1'b0
`define QPS_MODE_STRICT  1'b1

`endif

// ==== logic/qps_buf2.v ====
// two-entry output buffer with valid/ready on both sides
// assumes one clock, synchronous active-high reset, clock enable
`timescale 1ns/1ns
module qps_buf2 #(
   parameter W = 9
) (
   // clock and control
   input  wire         clk_sys,
   input  wire         srst,
   input  wire         ce,
   // fill side
   input  wire [W-1:0] s_data,
   input  wire         s_valid,
   output wire         s_ready,
   // drain side
   output reg  [W-1:0] m_data_r,
   output reg          m_valid_r,
   input  wire         m_ready
);
   reg [W-1:0] hold_r;
   reg         hold_vld_r;

   wire take = s_valid & s_ready & ce;
   wire give = m_valid_r & m_ready & ce;

   assign s_ready = ~hold_vld_r;

   always @(posedge clk_sys) begin
      if (srst) begin
         m_valid_r  <= 1'b0;
         hold_vld_r <= 1'b0;
         m_data_r   <= {W{1'b0}};
         hold_r     <= {W{1'b0}};
      end else if (ce) begin
         if (give || !m_valid_r) begin
            if (hold_vld_r) begin
               m_data_r   <= hold_r;
               m_valid_r  <= 1'b1;
               hold_vld_r <= take;
               if (take) begin
                  hold_r <= s_data;
               end
            end else begin
               m_data_r  <= s_data;
               m_valid_r <= take;
            end
         end else if (take) begin
            hold_r     <= s_data;
            hold_vld_r <= 1'b1;
         end
      end
   end
endmodule

// ==== logic/qps_sched.v ====
// ingress classifier, four egress queues and egress scheduler
// assumes ingress/egress byte streams and config from logic on clk_sys
`timescale 1ns/1ns
`include "qps_defs.vh"
module qps_sched #(
   parameter SW     = 2,
   parameter MAXLEN = 1536
) (
   // clock and control
   input  wire           clk_sys,
   input  wire           srst,
   input  wire           ce,
   // ingress stream
   input  wire [7:0]     in_data,
   input  wire           in_last,
   input  wire           in_valid,
   output reg            in_ready_r,
   // egress stream
   output wire [7:0]     out_data,
   output wire           out_last,
   output wire           out_valid,
   input  wire           out_ready,
   // configuration
   input  wire           tos_en,
   input  wire           cos_en,
   input  wire [2:0]     port_pri,
   input  wire           remark_en,
   input  wire [2:0]     remark_pri,
   input  wire [15:0]    cos_map,
   input  wire [191:0]   dscp_map,
   input  wire           sched_strict,
   input  wire           egr_tagged,
   // status
   output reg  [3:0]     q_nonempty_r,
   output reg            sched_mode_r
);
   localparam NSLOT = 1 << SW;
   localparam IW    = `QPS_IDX_W;
   localparam CW    = `QPS_CRED_W;

   reg [7:0]    fmem   [0:NSLOT*MAXLEN-1];
   reg [IW-1:0] slen   [0:NSLOT-1];
   reg [2:0]    spri   [0:NSLOT-1];
   reg          stag   [0:NSLOT-1];
   reg [SW-1:0] qfifo  [0:4*NSLOT-1];
   reg [SW-1:0] qhd    [0:3];
   reg [SW:0]   qct    [0:3];
   reg [CW-1:0] cred_r [0:3];
   reg [NSLOT-1:0] free_r;

   // ingress state
   reg          rx_act_r;
   reg [SW-1:0] rx_slot_r;
   reg [IW-1:0] rx_idx_r;
   reg [7:0]    etype_hi_r;
   reg          rx_tag_r;
   reg          rx_ip_r;
   reg          rx_tos_ok_r;
   reg [2:0]    rx_pcp_r;
   reg [5:0]    rx_dscp_r;

   // egress state
   reg          tx_act_r;
   reg [SW-1:0] tx_slot_r;
   reg [IW-1:0] tx_idx_r;

   // combinational helpers
   reg [SW-1:0]    alloc_slot;
   reg [NSLOT-1:0] free_nxt;
   reg             rx_act_nxt;
   reg [2:0]       cls_pri;
   reg [2:0]       fin_pri;
   reg [5:0]       dscp_now;
   reg [2:0]       pcp_now;
   reg [1:0]       fin_q;
   reg [1:0]       pick_q;
   reg             pick_vld;
   reg             reload;
   reg [CW-1:0]    wgt [0:3];
   integer         i;
   integer         j;

   wire            accept = in_valid & in_ready_r & ce;
   wire            is_sof = ~rx_act_r;
   wire [SW-1:0]   cur_slot = is_sof ? alloc_slot : rx_slot_r;
   wire [IW-1:0]   cur = is_sof ? {IW{1'b0}} : rx_idx_r;
   wire [15:0]     etype = {etype_hi_r, in_data};
   wire            tos_here = rx_ip_r & ((cur == `QPS_IDX_TOS_UT & ~rx_tag_r) |
                                         (cur == `QPS_IDX_TOS_T & rx_tag_r));
   wire            push = accept & in_last;
   wire            pop = ~tx_act_r & pick_vld & ce;
   wire            b_ready;
   wire            tx_go = tx_act_r & b_ready & ce;
   wire [IW-1:0]   tx_len = slen[tx_slot_r];
   wire            tx_end = tx_go & (tx_idx_r == tx_len - 1'b1);
   wire [7:0]      raw = fmem[tx_slot_r * MAXLEN + tx_idx_r];
   wire [7:0]      tx_byte = (tx_idx_r == `QPS_IDX_TCI && stag[tx_slot_r] && egr_tagged) ?
                             {spri[tx_slot_r], raw[4:0]} : raw;
   wire [1:0]      head_q = pick_q;
   wire [SW-1:0]   head_slot = qfifo[head_q * NSLOT + qhd[head_q]];
   wire            mode_now = tx_act_r ? sched_mode_r : sched_strict;

   always @* begin
      wgt[3] = `QPS_WGT_Q3;
      wgt[2] = `QPS_WGT_Q2;
      wgt[1] = `QPS_WGT_Q1;
      wgt[0] = `QPS_WGT_Q0;
      alloc_slot = {SW{1'b0}};
      for (i = NSLOT - 1; i >= 0; i = i - 1) begin
         if (free_r[i]) begin
            alloc_slot = i[SW-1:0];
         end
      end
      // tos or tag byte taken as the last byte is used directly
      dscp_now = (accept && tos_here) ? in_data[7:2] : rx_dscp_r;
      pcp_now = (accept && rx_tag_r && cur == `QPS_IDX_TCI) ? in_data[7:5] : rx_pcp_r;
      // tos first, then tag, then port default
      if (tos_en && (rx_tos_ok_r || (accept && tos_here))) begin
         cls_pri = dscp_map[dscp_now * 3 +: 3];
      end else if (cos_en && rx_tag_r) begin
         cls_pri = pcp_now;
      end else begin
         cls_pri = port_pri;
      end
      fin_pri = remark_en ? remark_pri : cls_pri;
      fin_q = cos_map[fin_pri * 2 +: 2];
      // scheduler pick
      pick_vld = 1'b0;
      pick_q = 2'h0;
      reload = 1'b0;
      if (mode_now == `QPS_MODE_STRICT) begin
         for (i = 0; i < 4; i = i + 1) begin
            if (qct[i] != 0) begin
               pick_vld = 1'b1;
               pick_q = i[1:0];
            end
         end
      end else begin
         for (i = 0; i < 4; i = i + 1) begin
            if (qct[i] != 0 && cred_r[i] != 0) begin
               pick_vld = 1'b1;
               pick_q = i[1:0];
            end
         end
         if (!pick_vld) begin
            for (i = 0; i < 4; i = i + 1) begin
               if (qct[i] != 0) begin
                  pick_vld = 1'b1;
                  reload = 1'b1;
                  pick_q = i[1:0];
               end
            end
         end
      end
      free_nxt = free_r;
      if (accept && is_sof) begin
         free_nxt[alloc_slot] = 1'b0;
      end
      if (tx_end) begin
         free_nxt[tx_slot_r] = 1'b1;
      end
      rx_act_nxt = accept ? ~in_last : rx_act_r;
   end

   // ingress capture and parse
   always @(posedge clk_sys) begin
      if (srst) begin
         rx_act_r    <= 1'b0;
         rx_slot_r   <= {SW{1'b0}};
         rx_idx_r    <= {IW{1'b0}};
         etype_hi_r  <= 8'h00;
         rx_tag_r    <= 1'b0;
         rx_ip_r     <= 1'b0;
         rx_tos_ok_r <= 1'b0;
         rx_pcp_r    <= 3'h0;
         rx_dscp_r   <= 6'h00;
         in_ready_r  <= 1'b0;
         free_r      <= {NSLOT{1'b1}};
      end else if (ce) begin
         free_r     <= free_nxt;
         in_ready_r <= rx_act_nxt | (free_nxt != 0);
         if (accept) begin
            rx_act_r  <= ~in_last;
            rx_slot_r <= cur_slot;
            if (cur < MAXLEN) begin
               fmem[cur_slot * MAXLEN + cur] <= in_data;
               slen[cur_slot] <= cur + 1'b1;
               rx_idx_r <= cur + 1'b1;
            end
            if (is_sof) begin
               rx_tag_r    <= 1'b0;
               rx_ip_r     <= 1'b0;
               rx_tos_ok_r <= 1'b0;
            end
            if (cur == `QPS_IDX_TYPE_HI || cur == `QPS_IDX_TYPE2_HI) begin
               etype_hi_r <= in_data;
            end
            if (cur == `QPS_IDX_TYPE_LO) begin
               rx_tag_r <= (etype == `QPS_TPID);
               rx_ip_r  <= (etype == `QPS_ETYPE_IP4);
            end
            if (cur == `QPS_IDX_TYPE2_LO && rx_tag_r) begin
               rx_ip_r <= (etype == `QPS_ETYPE_IP4);
            end
            if (cur == `QPS_IDX_TCI && rx_tag_r) begin
               rx_pcp_r <= in_data[7:5];
            end
            if (tos_here) begin
               rx_dscp_r   <= in_data[7:2];
               rx_tos_ok_r <= 1'b1;
            end
            if (in_last) begin
               spri[cur_slot] <= fin_pri;
               stag[cur_slot] <= rx_tag_r;
            end
         end
      end
   end

   // queues, credits and egress walk
   always @(posedge clk_sys) begin
      if (srst) begin
         tx_act_r     <= 1'b0;
         tx_slot_r    <= {SW{1'b0}};
         tx_idx_r     <= {IW{1'b0}};
         sched_mode_r <= `QPS_MODE_WFQ;
         q_nonempty_r <= 4'h0;
         for (j = 0; j < 4; j = j + 1) begin
            qhd[j]    <= {SW{1'b0}};
            qct[j]    <= {(SW+1){1'b0}};
            cred_r[j] <= wgt[j];
         end
      end else if (ce) begin
         if (!tx_act_r) begin
            sched_mode_r <= sched_strict;
         end
         for (j = 0; j < 4; j = j + 1) begin
            qct[j] <= qct[j] + ((push && fin_q == j) ? 1'b1 : 1'b0)
                      - ((pop && pick_q == j) ? 1'b1 : 1'b0);
            q_nonempty_r[j] <= (qct[j] + ((push && fin_q == j) ? 1'b1 : 1'b0)
                                - ((pop && pick_q == j) ? 1'b1 : 1'b0)) != 0;
         end
         if (push) begin
            qfifo[fin_q * NSLOT + ((qhd[fin_q] + qct[fin_q]) & (NSLOT - 1))] <= cur_slot;
         end
         if (pop) begin
            tx_slot_r    <= head_slot;
            tx_idx_r     <= {IW{1'b0}};
            tx_act_r     <= 1'b1;
            sched_mode_r <= sched_strict;
            qhd[pick_q]  <= qhd[pick_q] + 1'b1;
            if (sched_strict == `QPS_MODE_WFQ) begin
               if (reload) begin
                  for (j = 0; j < 4; j = j + 1) begin
                     cred_r[j] <= wgt[j];
                  end
                  cred_r[pick_q] <= wgt[pick_q] - 1'b1;
               end else begin
                  cred_r[pick_q] <= cred_r[pick_q] - 1'b1;
               end
            end
         end
         if (tx_go) begin
            tx_idx_r <= tx_idx_r + 1'b1;
            if (tx_end) begin
               tx_act_r <= 1'b0;
            end
         end
      end
   end

   qps_buf2 #(
      .W (9)
   ) u_obuf (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .ce        (ce),
      .s_data    ({tx_end, tx_byte}),
      .s_valid   (tx_act_r),
      .s_ready   (b_ready),
      .m_data_r  ({out_last, out_data}),
      .m_valid_r (out_valid),
      .m_ready   (out_ready)
   );
endmodule

// ==== tb/qps_sched_sva.sv ====
// port-level assertions for the qos scheduler
// assumes a single clk_sys domain with synchronous active-high srst
`timescale 1ns/1ns
module qps_sched_sva (
   // clock and control
   input wire       clk_sys,
   input wire       srst,
   input wire       ce,
   // ingress
   input wire       in_last,
   input wire       in_valid,
   input wire       in_ready_r,
   // egress
   input wire [7:0] out_data,
   input wire       out_last,
   input wire       out_valid,
   input wire       out_ready,
   // mode and status
   input wire       sched_strict,
   input wire [3:0] q_nonempty_r,
   input wire       sched_mode_r
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   out_hold_a: assert property (
      ce && out_valid && !out_ready |=> out_valid && $stable({out_last, out_data}))
      else $error("egress word changed while stalled");
   rst_clear_a: assert property (
      disable iff (1'b0) srst && ce |=> !in_ready_r && !out_valid && q_nonempty_r == 4'h0)
      else $error("reset did not clear outputs");
   mode_sample_a: assert property (
      sched_mode_r != $past(sched_mode_r) |-> sched_mode_r == $past(sched_strict))
      else $error("mode taken from wrong select");
   q_set_a: assert property (
      (q_nonempty_r & ~$past(q_nonempty_r)) != 4'h0 |-> $past(in_valid && in_ready_r && in_last && ce))
      else $error("queue filled without a finished frame");
   q_one_a: assert property (
      $countones(q_nonempty_r & ~$past(q_nonempty_r)) <= 1)
      else $error("one frame filled two queues");
   out_start_a: assert property (
      $rose(out_valid) |-> $past(q_nonempty_r, 2) != 4'h0)
      else $error("egress started with no queued frame");
   in_ready_a: assert property (
      ce && in_valid && in_ready_r && !in_last |=> in_ready_r)
      else $error("ingress stalled inside a frame");
   rel_ready_a: assert property (
      $fell(srst) |=> in_ready_r)
      else $error("ingress not ready after reset");
endmodule

bind qps_sched qps_sched_sva u_sva (
   .clk_sys(clk_sys), .srst(srst), .ce(ce), .in_last(in_last), .in_valid(in_valid),
   .in_ready_r(in_ready_r), .out_data(out_data), .out_last(out_last), .out_valid(out_valid),
   .out_ready(out_ready), .sched_strict(sched_strict), .q_nonempty_r(q_nonempty_r),
   .sched_mode_r(sched_mode_r));

// ==== tb/qps_sink.sv ====
// egress receiver model: drives ready, can hold off or stall at random
// assumes the scheduler's clk_sys and srst
`timescale 1ns/1ns
module qps_sink (
   // clock and reset
   input  wire clk_sys,
   input  wire srst,
   // stall control
   input  wire hold,
   input  wire jitter,
   // egress handshake
   output reg  out_ready_r
);
   always @(posedge clk_sys) begin
      if (srst || hold)
         out_ready_r <= 1'b0;
      else if (jitter)
         out_ready_r <= ($urandom % 4) != 0;
      else
         out_ready_r <= 1'b1;
   end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench: queue order, classification and tag rewrite
// assumes qps_sched with 16 slots and a stalling egress receiver
`timescale 1ns/1ns
module testbench;
   reg          clk_sys, srst, ce, in_last, in_valid, hold, jitter;
   reg  [7:0]   in_data, tos;
   reg          tos_en, cos_en, remark_en, sched_strict, egr_tagged, tg, ip;
   reg  [2:0]   port_pri, remark_pri;
   reg  [15:0]  cos_map;
   reg  [191:0] dscp_map;
   reg  [31:0]  r;
   reg  [3:0]   qn;
   wire         in_ready_r, out_last, out_valid, out_ready_r, sched_mode_r;
   wire [7:0]   out_data;
   wire [3:0]   q_nonempty_r;
   reg  [7:0]   fr [0:19];
   logic [8:0]  exp_q [$];
   integer      n_errors, checks_done, i, k, p;

   qps_sched #(.SW(4), .MAXLEN(64)) uut (
      .clk_sys(clk_sys), .srst(srst), .ce(ce), .in_data(in_data), .in_last(in_last),
      .in_valid(in_valid), .in_ready_r(in_ready_r), .out_data(out_data), .out_last(out_last),
      .out_valid(out_valid), .out_ready(out_ready_r), .tos_en(tos_en), .cos_en(cos_en),
      .port_pri(port_pri), .remark_en(remark_en), .remark_pri(remark_pri), .cos_map(cos_map),
      .dscp_map(dscp_map), .sched_strict(sched_strict), .egr_tagged(egr_tagged),
      .q_nonempty_r(q_nonempty_r), .sched_mode_r(sched_mode_r));
   qps_sink u_sink (.clk_sys(clk_sys), .srst(srst), .hold(hold), .jitter(jitter), .out_ready_r(out_ready_r));

   task chk(input [8:0] got, input [8:0] want);
      begin
         checks_done = checks_done + 1;
         if (got !== want) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, want);
         end
      end
   endtask

   task wrap_up;
      begin
         $display("checks %0d errors %0d", checks_done, n_errors);
         if (n_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask

   task tx;
      begin
         for (i = 0; i < 20; i = i + 1) begin
            in_valid <= 1'b1;
            in_data  <= fr[i];
            in_last  <= (i == 19);
            @(posedge clk_sys);
            while (!in_ready_r) @(posedge clk_sys);
         end
         in_valid <= 1'b0;
         #1 qn = q_nonempty_r;
         @(posedge clk_sys);
      end
   endtask

   task mk(input [7:0] id);
      begin
         for (i = 0; i < 20; i = i + 1) fr[i] = id ^ i[7:0];
         fr[12] = 8'h60;
      end
   endtask

   task push_fr(input rw, input [2:0] pri);
      begin
         for (i = 0; i < 20; i = i + 1)
            exp_q.push_back({i == 19, (i == 14 && rw) ? {pri, fr[14][4:0]} : fr[i]});
      end
   endtask

   task send_pri(input [7:0] id, input [2:0] pri);
      begin
         mk(id);
         port_pri <= pri;
         tx;
      end
   endtask

   task drain;
      begin
         for (i = 0; i < 4000 && exp_q.size() != 0; i = i + 1) @(posedge clk_sys);
         if (exp_q.size() != 0) chk(9'h000, 9'h1ff);
      end
   endtask

   always @(posedge clk_sys) begin
      if (!srst && out_valid && out_ready_r) begin
         if (exp_q.size() == 0)
            chk({out_last, out_data}, 9'bx);
         else
            chk({out_last, out_data}, exp_q.pop_front());
      end
   end

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   initial begin
      #(40 * 50000);
      n_errors = n_errors + 1;
      wrap_up;
   end

   initial begin
      srst = 1'b1; ce = 1'b1; in_valid = 1'b0; in_last = 1'b0; in_data = 8'h00; hold = 1'b1; jitter = 1'b0;
      tos_en = 1'b0; cos_en = 1'b0; remark_en = 1'b0; sched_strict = 1'b0; egr_tagged = 1'b0;
      port_pri = 3'h0; remark_pri = 3'h0; cos_map = 16'hfa50; n_errors = 0; checks_done = 0;
      k = $urandom(28968);
      for (i = 0; i < 6; i = i + 1) dscp_map[i*32 +: 32] = $urandom;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      // weighted fair, receiver held: eight top frames, one bottom, then reload
      for (k = 1; k <= 10; k = k + 1) send_pri(k, (k == 10) ? 3'h0 : 3'h7);
      for (k = 1; k <= 8; k = k + 1) begin mk(k); push_fr(0, 0); end
      mk(10); push_fr(0, 0);
      mk(9); push_fr(0, 0);
      hold <= 1'b0;
      drain;
      // strict: after the frame already picked, highest queue first
      hold <= 1'b1;
      sched_strict <= 1'b1;
      for (k = 0; k < 4; k = k + 1) send_pri(k + 20, 2 * k);
      mk(20); push_fr(0, 0);
      for (k = 3; k > 0; k = k - 1) begin mk(k + 20); push_fr(0, 0); end
      hold <= 1'b0;
      drain;
      chk({8'h00, sched_mode_r}, 9'h001);
      // random classification with a jittery receiver
      sched_strict <= 1'b0;
      jitter <= 1'b1;
      for (k = 0; k < 24; k = k + 1) begin
         for (i = 0; i < 20; i = i + 1) begin
            r = $urandom;
            fr[i] = r[7:0];
         end
         r = $urandom;
         {ip, tg} = r[1:0];
         tos_en <= r[2]; cos_en <= r[3]; remark_en <= r[4]; egr_tagged <= r[5];
         port_pri <= r[8:6]; remark_pri <= r[11:9];
         fr[12] = tg ? 8'h81 : 8'h60;
         fr[13] = 8'h00;
         fr[16] = 8'h60;
         if (ip && tg) {fr[16], fr[17]} = 16'h0800;
         if (ip && !tg) {fr[12], fr[13]} = 16'h0800;
         tos = tg ? fr[19] : fr[15];
         p = r[4] ? r[11:9] : (r[2] && ip) ? dscp_map[3*tos[7:2] +: 3] : (r[3] && tg) ? fr[14][7:5] : r[8:6];
         push_fr(tg && r[5], p[2:0]);
         tx;
         chk({5'h00, qn}, 9'h001 << cos_map[2*p +: 2]);
         drain;
      end
      wrap_up;
   end
endmodule
